/* File: wake_listen_radio_config_regs.sv */
// Configuration bank with the timed smart wake listen window and the
// radio setup fields, reached over AXI4-Lite.
// Assumes one 40 MHz clock; the wake event pin is asynchronous, the
// preamble, level, done and transmit inputs come from same-clock logic.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module wake_listen_radio_config_regs (
   input wire logic CLK_IN,
   input wire logic RESETN_IN,
   input wire logic AWVALID_IN,
   input wire logic [wlr_cfg_pkg::ADDR_W-1:0] AWADDR_IN,
   output logic AWREADY_OUT,
   input wire logic WVALID_IN,
   input wire logic [wlr_cfg_pkg::DATA_W-1:0] WDATA_IN,
   input wire logic [3:0] WSTRB_IN,
   output logic WREADY_OUT,
   output logic BVALID_OUT,
   output logic [1:0] BRESP_OUT,
   input wire logic BREADY_IN,
   input wire logic ARVALID_IN,
   input wire logic [wlr_cfg_pkg::ADDR_W-1:0] ARADDR_IN,
   output logic ARREADY_OUT,
   output logic RVALID_OUT,
   output logic [wlr_cfg_pkg::DATA_W-1:0] RDATA_OUT,
   output logic [1:0] RRESP_OUT,
   input wire logic RREADY_IN,
   input wire logic WAKE_EVENT_IN,
   input wire logic PREAMBLE_FOUND_IN,
   input wire logic [7:0] SIGNAL_LEVEL_IN,
   input wire logic RX_DONE_IN,
   input wire logic TX_ENTER_IN,
   output logic RADIO_POWER_OUT,
   output logic RX_ENABLE_OUT,
   output logic ROM_TABLE_LOAD_OUT,
   output logic [23:0] CARRIER_WORD_OUT,
   output logic [11:0] BIT_RATE_OUT,
   output logic [11:0] TONE_OFFSET_OUT,
   output logic [7:0] CORR_BW_OUT,
   output logic [1:0] CORR_PHASE_OUT,
   output logic [7:0] POST_FILTER_OUT,
   output logic [5:0] RX_LOOP_ADJUST_OUT,
   output logic [1:0] LOOP_TABLE_SEL_OUT,
   output logic [8:0] LEVEL_THRESHOLD_DBM_OUT
);
   import wlr_cfg_pkg::*;
   localparam int S_WIN = 0;
   localparam int S_PRE = int'(IDX_PRESCALE - IDX_WINDOW);
   localparam int S_LIM = int'(IDX_LIMIT - IDX_WINDOW);
   localparam int S_CLO = int'(IDX_CARRIER_LO - IDX_WINDOW);
   localparam int S_CMID = int'(IDX_CARRIER_MID - IDX_WINDOW);
   localparam int S_CHI = int'(IDX_CARRIER_HI - IDX_WINDOW);
   localparam int S_RLO = int'(IDX_RATE_LO - IDX_WINDOW);
   localparam int S_SHR = int'(IDX_SHARED - IDX_WINDOW);
   localparam int S_DLO = int'(IDX_DEV_LO - IDX_WINDOW);
   localparam int S_CBW = int'(IDX_CORR_BW - IDX_WINDOW);
   localparam int S_FLT = int'(IDX_FILTER - IDX_WINDOW);
   localparam int S_ADJ = int'(IDX_ADJUST - IDX_WINDOW);

   typedef struct packed {
      logic [2:0] sync;
      logic wake_level;
      logic aw_got;
      logic w_got;
      logic [9:0] waddr;
      logic [7:0] wdata;
      logic wstrb0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
      logic [REG_COUNT-1:0][7:0] bank;
      logic [7:0] ctrl;
      listen_state_type state;
      logic [7:0] win_cnt;
      logic rom_load;
      logic [8:0] thresh;
      logic [5:0] adjust;
   } bank_state_type;

   localparam bank_state_type RESET_STATE = '{
      sync: '0, wake_level: 1'b0, aw_got: 1'b0, w_got: 1'b0,
      waddr: '0, wdata: '0, wstrb0: 1'b0, bvalid: 1'b0,
      bresp: RESP_OKAY, rvalid: 1'b0, rdata: '0, rresp: RESP_OKAY,
      bank: {REG_COUNT{REG_RESET}}, ctrl: CTRL_RESET,
      state: ST_SLEEP, win_cnt: '0, rom_load: 1'b0,
      thresh: 9'(REG_RESET) - 9'(LEVEL_OFFSET_DBM), adjust: '0};

   bank_state_type cur;
   bank_state_type next_cur;
   logic tick;
   logic wake_rise;
   logic listen_en;
   logic level_mode;
   logic [1:0] sel;
   logic level_hit;
   logic detect;
   logic window_end;
   logic [9:0] ar_idx;
   logic [9:0] ar_slot;
   logic ar_in_bank;
   logic [9:0] w_slot;
   logic [7:0] status;

   // Listen window tick source
   wake_tick_gen u_tick (
      .clk_in(CLK_IN),
      .resetn_in(RESETN_IN),
      .run_in(cur.state == ST_LISTEN),
      .prescale_in(cur.bank[S_PRE]),
      .tick_out(tick)
   );

   // Control fields, wake edge and detection terms
   assign listen_en = cur.ctrl[CTRL_LISTEN_BIT];
   assign level_mode = cur.ctrl[CTRL_LEVEL_BIT];
   assign sel = cur.ctrl[CTRL_SEL_LSB +: 2];
   assign wake_rise = cur.sync[1] == cur.sync[2] && cur.sync[2] &&
                      !cur.wake_level;
   assign level_hit = level_mode && $signed({SIGNAL_LEVEL_IN[7],
                      SIGNAL_LEVEL_IN}) >= $signed(cur.thresh);
   assign detect = PREAMBLE_FOUND_IN || level_hit;
   assign window_end = cur.bank[S_WIN] == 8'h00 ||
                       (tick && cur.win_cnt == cur.bank[S_WIN] - 8'h01);
   assign ar_idx = ARADDR_IN[ADDR_W-1:2];
   assign ar_slot = ar_idx - IDX_WINDOW;
   assign ar_in_bank = ar_idx >= IDX_WINDOW && ar_slot < 10'(REG_COUNT);
   assign w_slot = cur.waddr - IDX_WINDOW;
   assign status = 8'({cur.bank[S_FLT] == 8'h00, cur.state});

   // Next state of bus slave, bank and listen sequencer
   always_comb begin
      next_cur = cur;
      next_cur.rom_load = 1'b0;
      next_cur.sync = {cur.sync[1:0], WAKE_EVENT_IN};
      if (cur.sync[1] == cur.sync[2]) begin
         next_cur.wake_level = cur.sync[2];
      end
      // Write address and data are taken in either order
      if (AWVALID_IN && AWREADY_OUT) begin
         next_cur.aw_got = 1'b1;
         next_cur.waddr = AWADDR_IN[ADDR_W-1:2];
      end
      if (WVALID_IN && WREADY_OUT) begin
         next_cur.w_got = 1'b1;
         next_cur.wdata = WDATA_IN[7:0];
         next_cur.wstrb0 = WSTRB_IN[0];
      end
      if (cur.bvalid && BREADY_IN) begin
         next_cur.bvalid = 1'b0;
      end
      if (cur.aw_got && cur.w_got && !cur.bvalid) begin
         next_cur.aw_got = 1'b0;
         next_cur.w_got = 1'b0;
         next_cur.bvalid = 1'b1;
         next_cur.bresp = RESP_OKAY;
         if (cur.waddr >= IDX_WINDOW && w_slot < 10'(REG_COUNT)) begin
            if (cur.wstrb0) begin
               next_cur.bank[w_slot] = cur.wdata;
            end
         end else if (cur.waddr == IDX_CONTROL) begin
            if (cur.wstrb0) begin
               next_cur.ctrl = cur.wdata;
            end
         end else if (cur.waddr != IDX_STATUS) begin
            next_cur.bresp = RESP_SLVERR;
         end
      end
      // Read answer held until taken
      if (cur.rvalid && RREADY_IN) begin
         next_cur.rvalid = 1'b0;
      end
      if (ARVALID_IN && ARREADY_OUT) begin
         next_cur.rvalid = 1'b1;
         next_cur.rresp = RESP_OKAY;
         if (ar_in_bank) begin
            next_cur.rdata = cur.bank[ar_slot];
         end else if (ar_idx == IDX_CONTROL) begin
            next_cur.rdata = cur.ctrl;
         end else if (ar_idx == IDX_STATUS) begin
            next_cur.rdata = status;
         end else begin
            next_cur.rdata = 8'h00;
            next_cur.rresp = RESP_SLVERR;
         end
      end
      next_cur.thresh = 9'({1'b0, next_cur.bank[S_LIM]}) -
                        9'(LEVEL_OFFSET_DBM);
      // adjust only for custom receive table
      next_cur.adjust = next_cur.ctrl[CTRL_SEL_LSB] ?
                        next_cur.bank[S_ADJ][ADJ_LSB +: 6] : 6'h00;
      if (TX_ENTER_IN && sel == 2'h0) begin
         next_cur.rom_load = 1'b1;
      end
      unique case (cur.state)
         ST_SLEEP: begin
            if (wake_rise && listen_en) begin
               next_cur.state = ST_LISTEN;
               next_cur.win_cnt = 8'h00;
               next_cur.rom_load = sel == 2'h0;
            end
         end
         ST_LISTEN: begin
            if (detect) begin
               next_cur.state = ST_RECEIVE;
            end else if (window_end) begin
               next_cur.state = ST_SLEEP;
            end else if (tick) begin
               next_cur.win_cnt = cur.win_cnt + 8'h01;
            end
         end
         ST_RECEIVE: begin
            if (RX_DONE_IN) begin
               next_cur.state = ST_SLEEP;
            end
         end
         default: begin
            next_cur.state = ST_SLEEP;
         end
      endcase
   end

   // State register
   always_ff @(posedge CLK_IN) begin
      if (!RESETN_IN) begin
         cur <= RESET_STATE;
      end else begin
         cur <= next_cur;
      end
   end

   // Bus handshakes and answers
   assign AWREADY_OUT = !cur.aw_got && !cur.bvalid;
   assign WREADY_OUT = !cur.w_got && !cur.bvalid;
   assign BVALID_OUT = cur.bvalid;
   assign BRESP_OUT = cur.bresp;
   assign ARREADY_OUT = !cur.rvalid;
   assign RVALID_OUT = cur.rvalid;
   assign RDATA_OUT = {24'h000000, cur.rdata};
   assign RRESP_OUT = cur.rresp;

   // radio and receiver on while awake
   assign RADIO_POWER_OUT = cur.state != ST_SLEEP;
   assign RX_ENABLE_OUT = cur.state != ST_SLEEP;
   assign ROM_TABLE_LOAD_OUT = cur.rom_load;
   assign CARRIER_WORD_OUT = {cur.bank[S_CHI], cur.bank[S_CMID],
                              cur.bank[S_CLO]};
   assign BIT_RATE_OUT = {cur.bank[S_SHR][RATE_HI_LSB +: 4],
                          cur.bank[S_RLO]};
   assign TONE_OFFSET_OUT = {cur.bank[S_SHR][DEV_HI_LSB +: 4],
                             cur.bank[S_DLO]};
   assign CORR_BW_OUT = cur.bank[S_CBW];
   assign CORR_PHASE_OUT = cur.bank[S_ADJ][PHASE_LSB +: 2];
   // filter value in 2 kHz steps
   assign POST_FILTER_OUT = cur.bank[S_FLT];
   assign RX_LOOP_ADJUST_OUT = cur.adjust;
   assign LOOP_TABLE_SEL_OUT = sel;
   assign LEVEL_THRESHOLD_DBM_OUT = cur.thresh;

   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RESETN_IN);

   property p_wake_power;
      cur.state == ST_SLEEP && wake_rise && listen_en
         |=> RADIO_POWER_OUT && RX_ENABLE_OUT ##1
             (RX_ENABLE_OUT || cur.bank[S_WIN] == 8'h00);
   endproperty
   a_wake_power: assert property (p_wake_power)
      else $error("receiver not enabled on wake");

   property p_listen_hold;
      cur.state == ST_LISTEN && !detect && !tick && cur.bank[S_WIN] != 0
         |=> cur.state == ST_LISTEN && $stable(cur.win_cnt);
   endproperty
   a_listen_hold: assert property (p_listen_hold)
      else $error("listen window left early");

   property p_window_sleep;
      cur.state == ST_LISTEN && !detect && window_end
         |=> !RX_ENABLE_OUT && !RADIO_POWER_OUT;
   endproperty
   a_window_sleep: assert property (p_window_sleep)
      else $error("no sleep after window end");

   property p_threshold;
      LEVEL_THRESHOLD_DBM_OUT + 9'(LEVEL_OFFSET_DBM) ==
         {1'b0, cur.bank[S_LIM]};
   endproperty
   a_threshold: assert property (p_threshold)
      else $error("threshold offset wrong");

   property p_carrier;
      CARRIER_WORD_OUT[23:16] == cur.bank[S_CHI] &&
         CARRIER_WORD_OUT[7:0] == cur.bank[S_CLO];
   endproperty
   a_carrier: assert property (p_carrier)
      else $error("carrier word order wrong");

   property p_rate;
      BIT_RATE_OUT[11:8] == cur.bank[S_SHR][3:0];
   endproperty
   a_rate: assert property (p_rate)
      else $error("data rate upper nibble wrong");

   property p_deviation;
      TONE_OFFSET_OUT == {cur.bank[S_SHR][7:4], cur.bank[S_DLO]};
   endproperty
   a_deviation: assert property (p_deviation)
      else $error("deviation assembly wrong");

   property p_corr_bw;
      CORR_BW_OUT == cur.bank[S_CBW];
   endproperty
   a_corr_bw: assert property (p_corr_bw)
      else $error("correlator bandwidth wrong");

   property p_filter_flag;
      status[STAT_FILTER_BIT] == (POST_FILTER_OUT == 8'h00);
   endproperty
   a_filter_flag: assert property (p_filter_flag)
      else $error("filter range flag wrong");

   property p_adjust;
      !LOOP_TABLE_SEL_OUT[0] |-> RX_LOOP_ADJUST_OUT == 6'h00;
   endproperty
   a_adjust: assert property (p_adjust)
      else $error("loop adjust applied for ROM receive table");

   property p_phase;
      CORR_PHASE_OUT == cur.bank[S_ADJ][1:0];
   endproperty
   a_phase: assert property (p_phase)
      else $error("correlator phase wrong");

   property p_rom_load;
      cur.state == ST_SLEEP && wake_rise && listen_en && sel == 2'h0
         |=> ROM_TABLE_LOAD_OUT ##1 !ROM_TABLE_LOAD_OUT || $past(TX_ENTER_IN);
   endproperty
   a_rom_load: assert property (p_rom_load)
      else $error("ROM table load missing");

   property p_readback;
      ARVALID_IN && ARREADY_OUT && ar_in_bank
         |=> RVALID_OUT && RDATA_OUT[7:0] == $past(cur.bank[ar_slot]);
   endproperty
   a_readback: assert property (p_readback)
      else $error("read data differs from register");

   c_listen_sleep: cover property (cur.state == ST_LISTEN ##1
                                   cur.state == ST_SLEEP);
   c_receive: cover property (cur.state == ST_LISTEN ##1
                              cur.state == ST_RECEIVE);
   c_write: cover property (BVALID_OUT && BREADY_IN);
endmodule
`default_nettype wire

/* File: wlr_cfg_pkg.sv */
// Register map, field layout, reset values and timing figures of the
// wake listen and radio configuration bank.
// Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
`default_nettype none
package wlr_cfg_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int REG_COUNT = 13;
   // Register indexes; the byte address is four times the index
   localparam logic [9:0] IDX_WINDOW = 10'h106;
   localparam logic [9:0] IDX_PRESCALE = 10'h107;
   localparam logic [9:0] IDX_LIMIT = 10'h108;
   localparam logic [9:0] IDX_CARRIER_LO = 10'h109;
   localparam logic [9:0] IDX_CARRIER_MID = 10'h10a;
   localparam logic [9:0] IDX_CARRIER_HI = 10'h10b;
   localparam logic [9:0] IDX_RATE_LO = 10'h10c;
   localparam logic [9:0] IDX_SHARED = 10'h10d;
   localparam logic [9:0] IDX_DEV_LO = 10'h10e;
   localparam logic [9:0] IDX_CORR_BW = 10'h10f;
   localparam logic [9:0] IDX_FILTER = 10'h110;
   localparam logic [9:0] IDX_SPARE = 10'h111;
   localparam logic [9:0] IDX_ADJUST = 10'h112;
   localparam logic [9:0] IDX_CONTROL = 10'h120;
   localparam logic [9:0] IDX_STATUS = 10'h121;
   // Field positions
   localparam int RATE_HI_LSB = 0;
   localparam int DEV_HI_LSB = 4;
   localparam int ADJ_LSB = 2;
   localparam int PHASE_LSB = 0;
   localparam int CTRL_LISTEN_BIT = 0;
   localparam int CTRL_LEVEL_BIT = 1;
   localparam int CTRL_SEL_LSB = 4;
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_FILTER_BIT = 2;
   // Reset values
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Timing: system clock and wake tick reference
   localparam int CLK_PERIOD_NS = 25;
   localparam int CLK_FREQ_KHZ = 1000000 / CLK_PERIOD_NS;
   localparam int REF_FREQ_KHZ = 6500;
   localparam int TICK_REF_MULT = 128;
   localparam int LEVEL_OFFSET_DBM = 107;
   typedef enum logic [1:0] {
      ST_SLEEP,
      ST_LISTEN,
      ST_RECEIVE
   } listen_state_type;
endpackage
`default_nettype wire

/* File: wake_tick_gen.sv */
// Wake tick generator: derives the 6.5 MHz reference as an enable from
// the system clock and counts 128 times prescale reference pulses.
// Assumes one system clock; run_in comes from logic on that clock.
`timescale 1ns/1ps
`default_nettype none
module wake_tick_gen #(
   parameter int CLK_KHZ = wlr_cfg_pkg::CLK_FREQ_KHZ,
   parameter int REF_KHZ = wlr_cfg_pkg::REF_FREQ_KHZ,
   parameter int MULT = wlr_cfg_pkg::TICK_REF_MULT
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic run_in,
   input wire logic [7:0] prescale_in,
   output logic tick_out
);
   import wlr_cfg_pkg::*;
   localparam int SHIFT = $clog2(MULT);
   localparam logic [16:0] REF_STEP = 17'(REF_KHZ);
   localparam logic [16:0] CLK_STEP = 17'(CLK_KHZ);
   typedef struct packed {
      logic [15:0] acc;
      logic [14:0] ref_cnt;
      logic tick;
   } tick_state_type;
   tick_state_type cur;
   tick_state_type next_cur;
   logic [16:0] sum;
   logic [14:0] last;

   // Fractional reference enable and tick count; prescale 0 acts as 1
   always_comb begin
      next_cur = cur;
      next_cur.tick = 1'b0;
      sum = {1'b0, cur.acc} + REF_STEP;
      // Last count of a tick: 128 times prescale minus one, 0 taken as 1
      last = (15'(prescale_in == 8'h00 ? 8'h01 : prescale_in) << SHIFT) -
             15'h1;
      next_cur.acc = sum[15:0];
      if (sum >= CLK_STEP) begin
         next_cur.acc = 16'(sum - CLK_STEP);
         if (run_in && cur.ref_cnt == last) begin
            next_cur.ref_cnt = '0;
            next_cur.tick = 1'b1;
         end else if (run_in) begin
            next_cur.ref_cnt = cur.ref_cnt + 15'h1;
         end
      end
      if (!run_in) begin
         next_cur.ref_cnt = '0;
      end
   end

   // State register
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign tick_out = cur.tick;

   property p_tick_spacing;
      @(posedge clk_in) disable iff (!resetn_in)
      cur.tick |-> $past(cur.ref_cnt) == $past(last) && $past(run_in);
   endproperty
   a_tick_spacing: assert property (p_tick_spacing)
      else $error("tick without full prescale count");
endmodule
`default_nettype wire

/* File: wake_listen_radio_config_regs_tb.sv */
// Self-checking bench for the wake listen and radio configuration bank.
// Assumes the bank alone; the bench is the AXI4-Lite master and drives
// the wake, preamble, level, done and transmit inputs itself.
`timescale 1ns/1ps
`default_nettype none
module wake_listen_radio_config_regs_tb;
   import wlr_cfg_pkg::*;
   localparam int LIMIT = 4000;
   logic clk = 0, rstn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, wake = 0, pre = 0, done = 0, tx = 0;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0;
   logic [7:0] lvl = 8'h80;
   logic awready, wready, bvalid, arready, rvalid, pwr, rxen, rom;
   logic [1:0] bresp, rresp, phase, sel;
   logic [31:0] rdata;
   logic [23:0] carrier;
   logic [11:0] rate, tone;
   logic [7:0] cbw, filt;
   logic [5:0] adj;
   logic [8:0] thr;
   int n_mismatch = 0;
   int n_compared = 0;

   // Free-running 40 MHz clock
   always #12.5 clk = ~clk;

   wake_listen_radio_config_regs u_dut (
      .CLK_IN(clk), .RESETN_IN(rstn),
      .AWVALID_IN(awvalid), .AWADDR_IN(awaddr), .AWREADY_OUT(awready),
      .WVALID_IN(wvalid), .WDATA_IN(wdata), .WSTRB_IN(4'h1),
      .WREADY_OUT(wready), .BVALID_OUT(bvalid), .BRESP_OUT(bresp),
      .BREADY_IN(bready), .ARVALID_IN(arvalid), .ARADDR_IN(araddr),
      .ARREADY_OUT(arready), .RVALID_OUT(rvalid), .RDATA_OUT(rdata),
      .RRESP_OUT(rresp), .RREADY_IN(rready), .WAKE_EVENT_IN(wake),
      .PREAMBLE_FOUND_IN(pre), .SIGNAL_LEVEL_IN(lvl), .RX_DONE_IN(done),
      .TX_ENTER_IN(tx), .RADIO_POWER_OUT(pwr), .RX_ENABLE_OUT(rxen),
      .ROM_TABLE_LOAD_OUT(rom), .CARRIER_WORD_OUT(carrier),
      .BIT_RATE_OUT(rate), .TONE_OFFSET_OUT(tone), .CORR_BW_OUT(cbw),
      .CORR_PHASE_OUT(phase), .POST_FILTER_OUT(filt),
      .RX_LOOP_ADJUST_OUT(adj), .LOOP_TABLE_SEL_OUT(sel),
      .LEVEL_THRESHOLD_DBM_OUT(thr));

   task automatic tally_and_finish();
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic fail(input string m);
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, m);
   endtask

   task automatic cmp(input logic [31:0] g, input logic [31:0] e,
                      input string m);
      n_compared++;
      if (g !== e) fail(m);
   endtask

   // One clock with a bound on the wait, then settle to the falling edge
   task automatic nstep(inout int n);
      @(posedge clk);
      n++;
      if (n > LIMIT) begin
         fail("wait limit reached");
         tally_and_finish();
      end
      @(negedge clk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d,
                     input logic [1:0] er);
      bit aw, w, ta, tw;
      int n;
      aw = 0;
      w = 0;
      n = 0;
      @(posedge clk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= {24'h0, d};
      @(negedge clk);
      // Release each channel at the edge that takes it
      while (!(aw && w)) begin
         ta = awvalid && awready;
         tw = wvalid && wready;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         aw = aw || ta;
         w = w || tw;
         if (aw && w) bready <= 1'b1;
         nstep(n);
      end
      while (!bvalid) nstep(n);
      cmp(32'(bresp), 32'(er), "write response");
      @(posedge clk);
      bready <= 1'b0;
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [7:0] e,
                        input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk);
      arvalid <= 1'b1;
      araddr <= a;
      @(negedge clk);
      while (!arready) nstep(n);
      @(posedge clk);
      arvalid <= 1'b0;
      rready <= 1'b1;
      @(negedge clk);
      while (!rvalid) nstep(n);
      cmp(rdata, {24'h0, e}, "read data");
      cmp(32'(rresp), 32'(er), "read response");
      @(posedge clk);
      rready <= 1'b0;
   endtask

   function automatic logic [7:0] val(input int i);
      return 8'(8'h3c + i * 29);
   endfunction

   task automatic t_reset();
      for (int i = 0; i < REG_COUNT; i++) begin
         rdchk(12'(12'h418 + 4 * i), 8'h00, RESP_OKAY);
      end
      rdchk(12'h484, 8'h04, RESP_OKAY);
      cmp(32'(thr), 32'(9'h195), "threshold after reset");
   endtask

   task automatic t_fields();
      int k;
      logic [7:0] v12;
      v12 = val(12);
      for (int i = 0; i < REG_COUNT; i++) wr(12'(12'h418 + 4 * i), val(i), 0);
      for (int i = 0; i < REG_COUNT; i++) begin
         rdchk(12'(12'h418 + 4 * i), val(i), RESP_OKAY);
      end
      cmp(32'(carrier), {8'h0, val(5), val(4), val(3)}, "carrier");
      cmp(32'(rate), 32'({val(7) & 8'h0f, val(6)}), "rate");
      cmp(32'(tone), 32'({val(7) >> 4, val(8)}), "deviation");
      cmp(32'(cbw), 32'(val(9)), "correlator bandwidth");
      cmp(32'(filt), 32'(val(10)), "post filter");
      // Filter near three quarters of the 202.6 kbps rate: 76 steps
      wr(12'h440, 8'h4c, RESP_OKAY);
      cmp(32'(filt), 32'h4c, "post filter near rate");
      cmp(32'(phase), 32'(v12[1:0]), "correlator phase");
      cmp(32'(thr), 32'(9'({1'b0, val(2)}) - 9'd107), "threshold");
      wr(12'h420, 8'hff, RESP_OKAY);
      cmp(32'(thr), 32'(9'h094), "top threshold");
      // Every loop table selection, with a transmit entry under each
      for (int s = 0; s < 4; s++) begin
         wr(12'h480, 8'(s << 4), RESP_OKAY);
         cmp(32'(sel), 32'(s), "table selection");
         cmp(32'(adj), (s % 2) ? 32'(v12[7:2]) : 0, "loop adjust");
         @(posedge clk);
         tx <= 1'b1;
         @(posedge clk);
         tx <= 1'b0;
         k = 0;
         repeat (4) begin
            @(negedge clk);
            k += int'(rom);
         end
         cmp(32'(k), (s == 0) ? 1 : 0, "table load on transmit");
      end
   endtask

   task automatic t_unmapped();
      wr(12'h400, 8'h5a, RESP_SLVERR);
      rdchk(12'h400, 8'h00, RESP_SLVERR);
      wr(12'h484, 8'hff, RESP_OKAY);
      rdchk(12'h484, 8'h00, RESP_OKAY);
   endtask

   task automatic t_window();
      int n, hi, roms;
      n = 0;
      hi = 0;
      roms = 0;
      wr(12'h418, 8'h02, RESP_OKAY);
      wr(12'h41c, 8'h01, RESP_OKAY);
      wr(12'h480, 8'h01, RESP_OKAY);
      @(posedge clk);
      wake <= 1'b1;
      @(negedge clk);
      while (!pwr) nstep(n);
      cmp(32'(n <= 8 && rxen), 1, "power-up on wake");
      while (pwr) begin
         roms += int'(rom);
         nstep(hi);
      end
      // Two ticks of 128 reference periods at 6.5 MHz
      cmp(32'(hi >= 1568 && hi <= 1590), 1, "listen length");
      cmp(32'(roms), 1, "table load on listen");
      @(posedge clk);
      wake <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   task automatic t_detect(input bit by_level);
      int n;
      n = 0;
      wr(12'h418, 8'h01, RESP_OKAY);
      wr(12'h420, 8'h20, RESP_OKAY);
      wr(12'h480, by_level ? 8'h03 : 8'h01, RESP_OKAY);
      @(posedge clk);
      wake <= 1'b1;
      repeat (20) @(posedge clk);
      rdchk(12'h484, 8'h01, RESP_OKAY);
      if (by_level) lvl <= 8'hc4;
      else pre <= 1'b1;
      @(posedge clk);
      pre <= 1'b0;
      lvl <= 8'h80;
      repeat (1000) @(posedge clk);
      @(negedge clk);
      cmp(32'(pwr && rxen), 1, "receive held past window");
      rdchk(12'h484, 8'h02, RESP_OKAY);
      @(posedge clk);
      done <= 1'b1;
      wake <= 1'b0;
      @(posedge clk);
      done <= 1'b0;
      @(negedge clk);
      while (pwr && n < 6) nstep(n);
      cmp(32'(pwr), 0, "sleep after receive");
   endtask

   // Reset, then the scenarios in turn
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_fields();
      t_unmapped();
      t_window();
      t_detect(1'b0);
      t_detect(1'b1);
      tally_and_finish();
   end
endmodule
`default_nettype wire
